//--- dsw_top.sv
// Data-space decode, ROM window and RAM page banking for the 8-bit core
//
// Contract
// - Six-entry 12-bit return stack holds call and interrupt return addresses.
// - Reads at 40h..7Fh come from program memory, not RAM.
// - Window shows 64 program bytes placed anywhere up to 1FFFh.
// - Program address is window pointer above the low six data-address bits.
// - Each pointer value moves the window in 64-byte steps.
// - Window pointer at C9h is write-only; software avoids reads and bit ops.
// - Pointer bits 6..0 form upper address bits; bit 7 unused.
// - Pointer not reset; software writes it before first window read.
// - Page select at CBh is write-only; no reads or bit instructions.
// - Bit 4 picks page two, bit 3 page one; 00h none.
// - Extra pages use addresses 00h..3Fh, steered by the page select.
// - At most one page bit; several enable pages in parallel.
// - Page select not cleared at start; software writes it first.
// - Page select unchanged by interrupts and calls.
// - At reset the two option bytes are read and applied first.
// - Option bytes sit outside the map, read without any address.
`timescale 1ns/100ps
module dsw_top (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Data-space access from the core
   input wire dsw_pkg::dsw_dreq_t i_dreq,
   output dsw_pkg::dsw_sel_t o_sel,
   output logic o_win_rd,
   output logic [12:0] o_win_addr,
   input wire logic [7:0] i_pmem_data,
   output logic [7:0] o_win_data,
   output logic o_win_vld,
   // Return stack
   input wire logic i_call,
   input wire logic i_ret,
   input wire logic [11:0] i_pc,
   output logic [11:0] o_ret_pc,
   output logic o_stk_full,
   output logic o_stk_empty,
   // Option bytes
   output logic o_opt_req,
   input wire logic i_opt_vld,
   input wire logic [7:0] i_opt_data,
   output logic [15:0] o_opt,
   output logic o_core_run,
   // Write-only register contents as they steer the logic
   output logic [6:0] o_window_page_bits,
   output logic o_page_conflict
);
   import dsw_pkg::*;

   // =========================================
   // State
   typedef struct packed {
      logic [7:0] rom_window_pointer;
      logic [7:0] ram_page_select;
      dsw_sel_t sel;
      logic win_rd;
      logic [12:0] win_addr;
      logic win_pend;
      logic [7:0] win_data;
      logic win_vld;
      logic conflict;
      logic ptr_set;
      logic page_set;
   } dsw_top_st_t;

   dsw_top_st_t s_r;
   dsw_top_st_t s_nxt;
   logic boot_done;
   logic [15:0] opt_w;
   logic [11:0] ret_w;
   logic full_w;
   logic empty_w;
   logic opt_req_w;

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [12:0] win_map(input logic [7:0] ptr, input logic [7:0] a);
      // Pointer above six offset bits: one pointer step is one 64-byte granule
      win_map = {ptr[DSW_WIN_PAGE_W-1:0], a[DSW_WIN_OFS_W-1:0]};
   endfunction

   // =========================================
   // Decode and register writes
   always_comb begin
      s_nxt = s_r;
      s_nxt.win_rd = 1'b0;
      s_nxt.win_vld = 1'b0;
      s_nxt.sel = '0;
      if (s_r.win_pend) begin
         s_nxt.win_data = i_pmem_data;
         s_nxt.win_vld = 1'b1;
      end
      s_nxt.win_pend = s_r.win_rd;
      if (boot_done) begin
         // Only plain writes change the registers; reads fall through untouched
         if (i_dreq.wr && i_dreq.addr == DSW_ADR_ROM_WINDOW_POINTER) begin
            s_nxt.rom_window_pointer = i_dreq.wdata;
            s_nxt.ptr_set = 1'b1;
         end
         if (i_dreq.wr && i_dreq.addr == DSW_ADR_RAM_PAGE_SELECT) begin
            s_nxt.ram_page_select = i_dreq.wdata;
            s_nxt.page_set = 1'b1;
         end
         if (i_dreq.rd && in_range(i_dreq.addr, DSW_WIN_LO, DSW_WIN_HI)) begin
            s_nxt.win_rd = 1'b1;
            s_nxt.win_addr = win_map(s_r.rom_window_pointer, i_dreq.addr);
         end
         if ((i_dreq.rd || i_dreq.wr) && in_range(i_dreq.addr, DSW_BANK_LO, DSW_BANK_HI)) begin
            // Raw bits, no priority: two set bits really enable both pages
            s_nxt.sel.page_one = s_r.ram_page_select[DSW_PAGE_ONE_BIT];
            s_nxt.sel.page_two = s_r.ram_page_select[DSW_PAGE_TWO_BIT];
            s_nxt.sel.base = !(s_r.ram_page_select[DSW_PAGE_ONE_BIT]
                               || s_r.ram_page_select[DSW_PAGE_TWO_BIT]);
         end
         s_nxt.sel.window = s_nxt.win_rd;
      end
      s_nxt.conflict = s_nxt.ram_page_select[DSW_PAGE_ONE_BIT] && s_nxt.ram_page_select[DSW_PAGE_TWO_BIT];
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s_r.sel <= '0;
         s_r.win_rd <= 1'b0;
         s_r.win_addr <= '0;
         s_r.win_pend <= 1'b0;
         s_r.win_data <= '0;
         s_r.win_vld <= 1'b0;
         // Tracks only whether a value was ever written, so checks skip the undefined start
         s_r.ptr_set <= 1'b0;
         s_r.page_set <= 1'b0;
      end else begin
         s_r.sel <= s_nxt.sel;
         s_r.win_rd <= s_nxt.win_rd;
         s_r.win_addr <= s_nxt.win_addr;
         s_r.win_pend <= s_nxt.win_pend;
         s_r.win_data <= s_nxt.win_data;
         s_r.win_vld <= s_nxt.win_vld;
         s_r.ptr_set <= s_nxt.ptr_set;
         s_r.page_set <= s_nxt.page_set;
      end
      // Deliberately outside reset: pointer, page select and conflict flag all hold whatever they had
      // Calls and interrupts have no path here, so the selection survives them
      s_r.rom_window_pointer <= s_nxt.rom_window_pointer;
      s_r.ram_page_select <= s_nxt.ram_page_select;
      s_r.conflict <= s_nxt.conflict;
   end

   // =========================================
   // Return stack and option loader
   dsw_ret_stack #(
      .DEPTH(DSW_STACK_DEPTH),
      .W(DSW_PC_W)
   ) u_stack (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_push(i_call),
      .i_pop(i_ret),
      .i_pc(i_pc),
      .o_top(ret_w),
      .o_full(full_w),
      .o_empty(empty_w)
   );

   dsw_opt_loader u_opt (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .o_opt_req(opt_req_w),
      .i_opt_vld(i_opt_vld),
      .i_opt_data(i_opt_data),
      .o_opt(opt_w),
      .o_ready(boot_done)
   );

   assign o_sel = s_r.sel;
   assign o_win_rd = s_r.win_rd;
   assign o_win_addr = s_r.win_addr;
   assign o_win_data = s_r.win_data;
   assign o_win_vld = s_r.win_vld;
   assign o_ret_pc = ret_w;
   assign o_stk_full = full_w;
   assign o_stk_empty = empty_w;
   assign o_opt_req = opt_req_w;
   assign o_opt = opt_w;
   assign o_core_run = boot_done;
   assign o_window_page_bits = s_r.rom_window_pointer[DSW_WIN_PAGE_W-1:0];
   assign o_page_conflict = s_r.conflict;

   // =========================================
   // Checks
   win_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (boot_done && i_dreq.rd && i_dreq.addr >= DSW_WIN_LO && i_dreq.addr <= DSW_WIN_HI && !i_dreq.wr)
      |=> (o_win_rd && o_win_addr == {$past(s_r.rom_window_pointer[6:0]), $past(i_dreq.addr[5:0])}))
      else $error("window address not pointer over offset");
   win_data_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_win_rd |=> ##1 (o_win_vld && o_win_data == $past(i_pmem_data)))
      else $error("window read not served from program memory");
   ptr_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (boot_done && i_dreq.wr && i_dreq.addr == DSW_ADR_ROM_WINDOW_POINTER)
      |=> (o_window_page_bits == $past(i_dreq.wdata[6:0])))
      else $error("window pointer write lost");
   ptr_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (!i_dreq.wr) |=> (!$past(s_r.ptr_set) || $stable(s_r.rom_window_pointer))
      && (!$past(s_r.page_set) || $stable(s_r.ram_page_select)))
      else $error("write-only register changed without a write");
   page_one_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (boot_done && i_dreq.rd && i_dreq.addr <= DSW_BANK_HI && s_r.ram_page_select == DSW_PAGE_ONE)
      |=> (o_sel.page_one && !o_sel.page_two && !o_sel.base))
      else $error("page one not steered");
   page_none_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (boot_done && i_dreq.wr && i_dreq.addr <= DSW_BANK_HI && s_r.ram_page_select == DSW_PAGE_NONE)
      |=> (o_sel.base && !o_sel.page_one && !o_sel.page_two))
      else $error("base bank not selected");
   page_both_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (boot_done && i_dreq.rd && i_dreq.addr <= DSW_BANK_HI && o_page_conflict)
      |=> (o_sel.page_one && o_sel.page_two))
      else $error("parallel pages not both enabled");
   call_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (s_r.page_set && (i_call || i_ret) && !(i_dreq.wr && i_dreq.addr == DSW_ADR_RAM_PAGE_SELECT))
      |=> $stable(s_r.ram_page_select))
      else $error("page select disturbed by call or return");
   boot_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !boot_done |=> !o_win_rd && o_sel == '0)
      else $error("access served before option load");
endmodule

//--- dsw_pkg.sv
// Package: constants and carrier types for the data-space window and banking block
package dsw_pkg;
   // Data-space map
   localparam logic [7:0] DSW_BANK_LO = 8'h00;
   localparam logic [7:0] DSW_BANK_HI = 8'h3F;
   localparam logic [7:0] DSW_WIN_LO = 8'h40;
   localparam logic [7:0] DSW_WIN_HI = 8'h7F;
   localparam logic [7:0] DSW_ADR_ROM_WINDOW_POINTER = 8'hC9;
   localparam logic [7:0] DSW_ADR_RAM_PAGE_SELECT = 8'hCB;
   // Field layout
   localparam int DSW_WIN_OFS_W = 6;
   localparam int DSW_WIN_PAGE_W = 7;
   localparam int DSW_PAGE_ONE_BIT = 3;
   localparam int DSW_PAGE_TWO_BIT = 4;
   localparam logic [7:0] DSW_PAGE_NONE = 8'h00;
   localparam logic [7:0] DSW_PAGE_ONE = 8'h08;
   localparam logic [7:0] DSW_PAGE_TWO = 8'h10;
   // Stack and option bytes
   localparam int DSW_STACK_DEPTH = 6;
   localparam int DSW_PC_W = 12;
   localparam int DSW_OPT_BYTES = 2;
   localparam logic [7:0] DSW_OPT_RESET = 8'h00;
   localparam logic [2:0] DSW_SP_RESET = 3'h0;

   typedef enum logic [3:0] {
      DSW_ST_OPT0 = 4'h1,
      DSW_ST_OPT1 = 4'h2,
      DSW_ST_WAIT = 4'h4,
      DSW_ST_RUN = 4'h8
   } dsw_boot_t;

   // One data-space access from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dsw_dreq_t;

   // Program-memory fetch for window reads / option loads
   typedef struct packed {
      logic req;
      logic opt;
      logic [12:0] addr;
   } dsw_preq_t;

   // Select lines toward RAM storage
   typedef struct packed {
      logic base;
      logic page_one;
      logic page_two;
      logic window;
   } dsw_sel_t;
endpackage

//--- dsw_ret_stack.sv
// Six-level hardware return stack
`timescale 1ns/100ps
module dsw_ret_stack #(
   parameter int DEPTH = dsw_pkg::DSW_STACK_DEPTH,
   parameter int W = dsw_pkg::DSW_PC_W
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Push / pop
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic [W-1:0] i_pc,
   output logic [W-1:0] o_top,
   output logic o_full,
   output logic o_empty
);
   import dsw_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] ent;
      logic [2:0] sp;
      logic [W-1:0] top;
   } dsw_stk_t;

   dsw_stk_t st_r;
   dsw_stk_t st_nxt;

   // =========================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      if (i_push && st_r.sp < 3'(DEPTH)) begin
         st_nxt.ent[st_r.sp] = i_pc;
         st_nxt.sp = st_r.sp + 3'h1;
         st_nxt.top = i_pc;
      end else if (i_pop && st_r.sp != 3'h0) begin
         st_nxt.sp = st_r.sp - 3'h1;
         st_nxt.top = (st_r.sp > 3'h1) ? st_r.ent[st_r.sp - 3'h2] : st_r.ent[0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_r.sp <= DSW_SP_RESET;
         st_r.top <= '0;
      end else begin
         st_r.sp <= st_nxt.sp;
         st_r.top <= st_nxt.top;
      end
      // Entries carry no reset: only the pointer decides validity
      st_r.ent <= st_nxt.ent;
   end

   assign o_top = st_r.top;
   assign o_full = (st_r.sp == 3'(DEPTH));
   assign o_empty = (st_r.sp == 3'h0);

   // =========================================
   // Checks
   stack_depth_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) st_r.sp <= 3'(DEPTH))
      else $error("stack pointer beyond six levels");
   push_top_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_push && !o_full) |=> (o_top == $past(i_pc)))
      else $error("pushed address not on top");
endmodule

//--- dsw_opt_loader.sv
// Reset-time loader for the two option bytes
`timescale 1ns/100ps
module dsw_opt_loader (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Option store, addressless byte stream
   output logic o_opt_req,
   input wire logic i_opt_vld,
   input wire logic [7:0] i_opt_data,
   // Result
   output logic [15:0] o_opt,
   output logic o_ready
);
   import dsw_pkg::*;

   typedef struct packed {
      dsw_boot_t st;
      logic [7:0] lo;
      logic [7:0] hi;
      logic rdy;
   } dsw_ld_t;

   dsw_ld_t s_r;
   dsw_ld_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         DSW_ST_OPT0: begin
            if (i_opt_vld) begin
               s_nxt.lo = i_opt_data;
               s_nxt.st = DSW_ST_OPT1;
            end
         end
         DSW_ST_OPT1: begin
            if (i_opt_vld) begin
               s_nxt.hi = i_opt_data;
               s_nxt.st = DSW_ST_RUN;
               s_nxt.rdy = 1'b1;
            end
         end
         DSW_ST_RUN: s_nxt = s_r;
         default: s_nxt.st = DSW_ST_OPT0;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s_r <= '{st: DSW_ST_OPT0, lo: DSW_OPT_RESET, hi: DSW_OPT_RESET, rdy: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // The store is sequenced, no address is ever presented
   assign o_opt_req = !s_r.rdy;
   assign o_opt = {s_r.hi, s_r.lo};
   assign o_ready = s_r.rdy;

   opt_done_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (s_r.st == DSW_ST_OPT1 && i_opt_vld) |=> (o_ready && o_opt[15:8] == $past(i_opt_data)))
      else $error("second option byte not taken");
endmodule

//--- dsw_pmem_model.sv
// Far-side model: program memory behind the window and the option byte store
`timescale 1ns/100ps
module dsw_pmem_model #(
   parameter logic [7:0] OPT_LO = 8'h5A,
   parameter logic [7:0] OPT_HI = 8'hA5
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Window fetch
   input wire logic i_win_rd,
   input wire logic [12:0] i_win_addr,
   output logic [7:0] o_pmem_data,
   // Option stream
   input wire logic i_opt_req,
   output logic o_opt_vld,
   output logic [7:0] o_opt_data
);
   logic [1:0] sent_r;

   // ==========================================
   // Program memory and option bytes
   always_ff @(posedge i_clk_sys) begin
      // Data is only good the cycle after a fetch; otherwise it churns so stale reads show up
      if (i_win_rd) begin
         o_pmem_data <= i_win_addr[7:0] ^ {i_win_addr[12:8], 3'h5};
      end else begin
         o_pmem_data <= ~o_pmem_data;
      end
      if (i_rst) begin
         sent_r <= 2'h0;
         o_opt_vld <= 1'b0;
         o_opt_data <= 8'h3C;
         o_pmem_data <= 8'hC3;
      end else if (i_opt_req && sent_r < 2'h2) begin
         // Addressless stream, low byte first
         o_opt_vld <= 1'b1;
         o_opt_data <= sent_r[0] ? OPT_HI : OPT_LO;
         sent_r <= sent_r + 2'h1;
      end else begin
         o_opt_vld <= 1'b0;
         o_opt_data <= ~o_opt_data;
      end
   end
endmodule

//--- tb.sv
// Testbench for the data-space window, banking, stack and option loader
`timescale 1ns/100ps
module tb;
   import dsw_pkg::*;
   localparam logic [7:0] LO = 8'h5A;
   localparam logic [7:0] HI = 8'hA5;
   logic i_clk_sys, i_rst, i_call, i_ret, win_rd, win_vld, stk_full, stk_empty, opt_req, opt_vld, core_run, conflict;
   logic [11:0] i_pc, ret_pc;
   logic [12:0] win_addr;
   logic [7:0] pmem, opt_data, win_data;
   logic [15:0] opt;
   logic [6:0] page_bits;
   logic [11:0] stk_v [6];
   dsw_dreq_t dreq;
   dsw_sel_t sel;
   int fail_count, n_compared;

   dsw_top dsw_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_dreq(dreq), .o_sel(sel), .o_win_rd(win_rd),
      .o_win_addr(win_addr), .i_pmem_data(pmem), .o_win_data(win_data), .o_win_vld(win_vld), .i_call(i_call),
      .i_ret(i_ret), .i_pc(i_pc), .o_ret_pc(ret_pc), .o_stk_full(stk_full), .o_stk_empty(stk_empty),
      .o_opt_req(opt_req), .i_opt_vld(opt_vld), .i_opt_data(opt_data), .o_opt(opt), .o_core_run(core_run),
      .o_window_page_bits(page_bits), .o_page_conflict(conflict));
   dsw_pmem_model #(.OPT_LO(LO), .OPT_HI(HI)) dsw_pmem_model_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_win_rd(win_rd), .i_win_addr(win_addr), .o_pmem_data(pmem), .i_opt_req(opt_req), .o_opt_vld(opt_vld),
      .o_opt_data(opt_data));

   // ==========================================
   // Compare and bus tasks
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task chk_b(input string name, input logic exp, input logic got);
      chk(name, {15'h0, exp}, {15'h0, got});
   endtask
   function automatic logic [7:0] pbyte(input logic [12:0] a);
      return a[7:0] ^ {a[12:8], 3'h5};
   endfunction
   task acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      dreq <= {r, w, a, d};
   endtask
   // Request, idle, then look just after the taking edge while the one-cycle answer stands
   task op(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
      acc(r, w, a, d);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
   endtask
   task win(input logic [7:0] a, input logic [12:0] pa);
      op(1'b1, 1'b0, a, 8'h00);
      chk_b("win_rd", 1'b1, win_rd);
      chk("win_addr", {3'h0, pa}, {3'h0, win_addr});
      chk("sel", 16'h0001, {12'h000, sel});
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk_b("win_vld", 1'b1, win_vld);
      chk("win_data", {8'h00, pbyte(pa)}, {8'h00, win_data});
   endtask
   task bank(input logic [7:0] a, input logic [3:0] e);
      op(1'b1, 1'b0, a, 8'h00);
      chk("sel", {12'h000, e}, {12'h000, sel});
   endtask
   task stk(input logic c, input logic r, input logic [11:0] p);
      @(posedge i_clk_sys);
      i_call <= c;
      i_ret <= r;
      i_pc <= p;
      @(posedge i_clk_sys);
      i_call <= 1'b0;
      i_ret <= 1'b0;
      @(posedge i_clk_sys);
      #1;
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========================================
   // Clock, watchdog and tests
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   // The whole sequence needs about a hundred cycles
   initial begin
      repeat (3000) @(posedge i_clk_sys);
      fail_count++;
      $display("MISMATCH watchdog expected done seen timeout");
      close_out();
   end
   initial begin
      i_rst = 1'b1;
      i_call = 1'b0;
      i_ret = 1'b0;
      i_pc = 12'h000;
      dreq = '0;
      fail_count = 0;
      n_compared = 0;
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int k = 0; k < 20 && core_run !== 1'b1; k++) @(posedge i_clk_sys);
      #1;
      chk_b("core_run", 1'b1, core_run);
      chk("opt", {HI, LO}, opt);
      chk_b("opt_req", 1'b0, opt_req);
      op(1'b0, 1'b1, DSW_ADR_ROM_WINDOW_POINTER, 8'hFF);
      chk("page_bits", 16'h007F, {9'h000, page_bits});
      win(DSW_WIN_HI, 13'h1FFF);
      op(1'b0, 1'b1, DSW_ADR_ROM_WINDOW_POINTER, 8'h00);
      win(DSW_WIN_LO, 13'h0000);
      op(1'b0, 1'b1, DSW_ADR_ROM_WINDOW_POINTER, 8'h01);
      win(DSW_WIN_LO, 13'h0040);
      win(8'h65, 13'h0065);
      op(1'b1, 1'b0, DSW_ADR_ROM_WINDOW_POINTER, 8'h00);
      chk("page_bits", 16'h0001, {9'h000, page_bits});
      op(1'b0, 1'b1, DSW_ADR_RAM_PAGE_SELECT, DSW_PAGE_NONE);
      bank(DSW_BANK_LO, 4'b1000);
      op(1'b0, 1'b1, DSW_ADR_RAM_PAGE_SELECT, DSW_PAGE_ONE);
      bank(DSW_BANK_LO, 4'b0100);
      bank(DSW_BANK_HI, 4'b0100);
      chk_b("empty", 1'b1, stk_empty);
      for (int k = 0; k < 6; k++) begin
         stk_v[k] = 12'hA00 + 12'(k * 37);
         stk(1'b1, 1'b0, stk_v[k]);
         chk("top", {4'h0, stk_v[k]}, {4'h0, ret_pc});
      end
      chk_b("full", 1'b1, stk_full);
      stk(1'b1, 1'b0, 12'hFFF);
      for (int k = 5; k >= 0; k--) begin
         chk("top", {4'h0, stk_v[k]}, {4'h0, ret_pc});
         stk(1'b0, 1'b1, 12'h000);
      end
      chk_b("empty", 1'b1, stk_empty);
      bank(8'h20, 4'b0100);
      op(1'b1, 1'b0, DSW_ADR_RAM_PAGE_SELECT, 8'h00);
      chk_b("conflict", 1'b0, conflict);
      bank(8'h10, 4'b0100);
      op(1'b0, 1'b1, DSW_ADR_RAM_PAGE_SELECT, DSW_PAGE_TWO);
      bank(DSW_BANK_HI, 4'b0010);
      op(1'b0, 1'b1, DSW_ADR_RAM_PAGE_SELECT, 8'h18);
      bank(8'h10, 4'b0110);
      chk_b("conflict", 1'b1, conflict);
      close_out();
   end
endmodule
